// ### src/obm_pkg.sv
package obm_pkg;
	// Register byte offsets
	localparam logic [7:0] OBM_REG_CMD  = 8'h00;
	localparam logic [7:0] OBM_REG_ARG  = 8'h04;
	localparam logic [7:0] OBM_REG_DC   = 8'h08;
	localparam logic [7:0] OBM_REG_CFG  = 8'h0C;
	localparam logic [7:0] OBM_REG_STAT = 8'h10;
	localparam logic [7:0] OBM_REG_HDR  = 8'h14;
	localparam logic [7:0] OBM_REG_AID  = 8'h18;
	localparam logic [7:0] OBM_REG_AMSK = 8'h1C;
	// Command word fields
	localparam int OBM_OP_LSB  = 0;
	localparam int OBM_DIG_LSB = 4;
	// Command opcodes
	localparam logic [3:0] OBM_OP_SET_HDR  = 4'h1;
	localparam logic [3:0] OBM_OP_MON_ALL  = 4'h2;
	localparam logic [3:0] OBM_OP_MON_TX   = 4'h3;
	localparam logic [3:0] OBM_OP_MON_RX   = 4'h4;
	localparam logic [3:0] OBM_OP_CRA      = 4'h5;
	localparam logic [3:0] OBM_OP_HFMT_OFF = 4'h6;
	localparam logic [3:0] OBM_OP_HFMT_ON  = 4'h7;
	// Digit counts of interest
	localparam logic [3:0] OBM_DIG_NONE  = 4'h0;
	localparam logic [3:0] OBM_DIG_SHORT = 4'h3;
	localparam logic [3:0] OBM_DIG_FULL  = 4'h8;
	// Config bits
	localparam int OBM_CFG_AUTO = 0;
	localparam int OBM_CFG_EXT  = 1;
	// Identifier masks
	localparam logic [31:0] OBM_ID11_MASK = 32'h0000_07FF;
	localparam logic [31:0] OBM_ID29_MASK = 32'h1FFF_FFFF;
	localparam logic [31:0] OBM_SHORT_MSK = 32'h0000_0FFF;
	localparam logic [31:0] OBM_HDR3_MSK  = 32'h00FF_FFFF;
	localparam logic [31:0] OBM_PRIO_MSK  = 32'hFF00_0000;
	localparam logic [2:0]  OBM_RX11_MSK  = 3'h7;
	// Reset values
	localparam logic [31:0] OBM_HDR_RST   = 32'h0000_0000;
	localparam logic [31:0] OBM_ZERO32    = 32'h0000_0000;
	localparam logic [7:0]  OBM_ZERO8     = 8'h00;
	// AXI responses
	localparam logic [1:0] OBM_RESP_OK  = 2'h0;
	localparam logic [1:0] OBM_RESP_ERR = 2'h2;

	// Controller states, one-hot
	typedef enum logic [2:0] {
		OBM_ST_IDLE = 3'b001,
		OBM_ST_MON  = 3'b010,
		OBM_ST_STOP = 3'b100
	} obm_state_e;

	// Monitor filter selection
	typedef enum logic [1:0] {
		OBM_MM_ALL = 2'h0,
		OBM_MM_TX  = 2'h1,
		OBM_MM_RX  = 2'h2
	} obm_mode_e;

	// Received frame identifier
	typedef struct packed {
		logic        ext;
		logic [28:0] id;
	} obm_frame_s;
endpackage

// ### src/obm_monitor.sv
// Behaviour
// - three-digit header gets leading zeros
// - monitor-all shows every frame that passes the acceptance filter
// - silent on bus while monitoring
// - RTS low or any character stops
// - interrupting character is discarded
// - finish line, then stopped and idle in the same cycle
// - quiet bus with auto search starts search
// - later request corrects K-line guess
// - transmitter filter matches third header byte
// - 11-bit id in low header bits
// - receiver filter matches middle header byte
// - 11-bit receiver compare uses low three bits
// - every frame received, then judged
// - full receive address gives exact match
// - X digit makes nibble don't-care
// - four-byte receive address for 29-bit
// - heavy header format can be turned off
// - receive address resolves to nibbles only
// - mask one compares, mask zero ignores
// - 29-bit priority byte uses low five bits
module obm_monitor
	import obm_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              frame_valid,
	input  obm_frame_s             frame_in,
	output obm_frame_s             disp_frame,
	output logic                   disp_valid,
	input  wire logic              disp_ready,
	input  wire logic              line_busy,
	input  wire logic              rx_char_valid,
	input  wire logic              rts_n_pin,
	output logic                   char_drop,
	output logic                   stopped,
	output logic                   busy,
	output logic                   can_ack_en,
	output logic                   wakeup_en,
	output logic                   bus_quiet_unused_n,
	input  wire logic              bus_quiet,
	output logic                   search_start,
	input  wire logic              search_kline_9141,
	input  wire logic              diag_req,
	output logic                   kline_recheck,
	output logic                   hdr_raw
);
	// Offsets need six address bits; a wider bus would alias onto the map
	if (ADDR_W < 6 || ADDR_W > 8) begin : g_addr_chk
		$error("ADDR_W outside the register map range");
	end

	// Nibble enable mask from the don't-care digit bits
	function automatic logic [31:0] nib_mask(input logic [7:0] dc);
		logic [31:0] m;
		m = OBM_ZERO32;
		for (int i = 0; i < 8; i++) begin
			m[i*4 +: 4] = dc[i] ? 4'h0 : 4'hF;
		end
		return m;
	endfunction

	// Receiver byte of a frame's header view
	function automatic logic [7:0] rx_byte(input obm_frame_s f);
		if (f.ext) begin
			return f.id[15:8];
		end
		return {5'h00, f.id[10:8]};
	endfunction

	// ---------------- Register bus state ----------------
	logic              awready_r, awready_nxt;
	logic              wready_r, wready_nxt;
	logic              aw_have_r, aw_have_nxt;   // Address latched
	logic              w_have_r, w_have_nxt;     // Data latched
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0]       wdata_r, wdata_nxt;
	logic [3:0]        wstrb_r, wstrb_nxt;
	logic              bvalid_r, bvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic              arready_r, arready_nxt;
	logic              rvalid_r, rvalid_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [1:0]        rresp_r, rresp_nxt;
	logic [31:0]       arg_r, arg_nxt;           // Command argument digits
	logic [7:0]        dc_r, dc_nxt;             // Don't-care digit flags
	logic [1:0]        cfg_r, cfg_nxt;           // Auto search, 29-bit bus
	logic [7:0]        cmd_r, cmd_nxt;           // Opcode and digit count
	logic              fire_r, fire_nxt;         // One-cycle command strobe

	// ---------------- Core state ----------------
	obm_state_e  state_r, state_nxt;
	obm_mode_e   mode_r, mode_nxt;
	logic [7:0]  maddr_r, maddr_nxt;             // Monitor address
	logic [31:0] hdr_r, hdr_nxt;                 // Priority plus three bytes
	logic [31:0] aid_r, aid_nxt;                 // Acceptance filter
	logic [31:0] amsk_r, amsk_nxt;               // Acceptance mask
	logic        hraw_r, hraw_nxt;
	obm_frame_s  dfr_r, dfr_nxt;
	logic        dval_r, dval_nxt;
	logic        drop_r, drop_nxt;
	logic        stop_r, stop_nxt;
	logic        srch_r, srch_nxt;
	logic        kgs_r, kgs_nxt;                 // K-line guess pending
	logic        rchk_r, rchk_nxt;
	logic        rts_meta_r, rts_sync_r;         // Pin synchroniser

	logic [7:0]  wofs, rofs;
	logic [31:0] mask_w, sel_w, stat_w;
	logic        acc_w, mon_w;

	assign wofs = 8'(awaddr_r);
	assign rofs = 8'(s_axi_araddr);

	// Status word: state, mode, guess flag, header view
	assign stat_w = {24'h00_0000, kgs_r, hraw_r, mode_r, 1'b0, state_r};

	// Register bus next state; write and read run independently
	always_comb begin
		awready_nxt = awready_r;
		wready_nxt  = wready_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		arready_nxt = 1'b0;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		arg_nxt     = arg_r;
		dc_nxt      = dc_r;
		cfg_nxt     = cfg_r;
		cmd_nxt     = cmd_r;
		fire_nxt    = 1'b0;
		// Address and data accepted in either order
		if (s_axi_awvalid && awready_r) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
			awready_nxt = 1'b0;
		end
		if (s_axi_wvalid && wready_r) begin
			w_have_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
			wready_nxt = 1'b0;
		end
		// Both halves held: perform the write once
		if (aw_have_r && w_have_r && !bvalid_r) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = OBM_RESP_OK;
			case (wofs)
				OBM_REG_ARG: begin
					for (int b = 0; b < 4; b++) begin
						if (wstrb_r[b]) begin
							arg_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
						end
					end
				end
				OBM_REG_DC: begin
					if (wstrb_r[0]) begin
						dc_nxt = wdata_r[7:0];
					end
				end
				OBM_REG_CFG: begin
					if (wstrb_r[0]) begin
						cfg_nxt = wdata_r[1:0];
					end
				end
				OBM_REG_CMD: begin
					// Commands only run while waiting for the host
					if (wstrb_r[0] && state_r == OBM_ST_IDLE) begin
						cmd_nxt  = wdata_r[7:0];
						fire_nxt = 1'b1;
					end
				end
				default: begin
					bresp_nxt = OBM_RESP_ERR;
				end
			endcase
		end
		// Response taken: reopen both channels
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt  = 1'b0;
			awready_nxt = 1'b1;
			wready_nxt  = 1'b1;
		end
		// Read: one cycle ready pulse, data valid in the same cycle
		if (s_axi_arvalid && !arready_r && !rvalid_r) begin
			arready_nxt = 1'b1;
			rvalid_nxt  = 1'b1;
			rresp_nxt   = OBM_RESP_OK;
			case (rofs)
				OBM_REG_CMD:  rdata_nxt = {24'h00_0000, cmd_r};
				OBM_REG_ARG:  rdata_nxt = arg_r;
				OBM_REG_DC:   rdata_nxt = {24'h00_0000, dc_r};
				OBM_REG_CFG:  rdata_nxt = {30'h0000_0000, cfg_r};
				OBM_REG_STAT: rdata_nxt = stat_w;
				OBM_REG_HDR:  rdata_nxt = hdr_r;
				OBM_REG_AID:  rdata_nxt = aid_r;
				OBM_REG_AMSK: rdata_nxt = amsk_r;
				default: begin
					rdata_nxt = OBM_ZERO32;
					rresp_nxt = OBM_RESP_ERR;
				end
			endcase
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// Register bus flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= OBM_ZERO32;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= OBM_RESP_OK;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= OBM_ZERO32;
			rresp_r   <= OBM_RESP_OK;
			arg_r     <= OBM_ZERO32;
			dc_r      <= OBM_ZERO8;
			cfg_r     <= 2'h0;
			cmd_r     <= OBM_ZERO8;
			fire_r    <= 1'b0;
		end else begin
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			awaddr_r  <= awaddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
			arg_r     <= arg_nxt;
			dc_r      <= dc_nxt;
			cfg_r     <= cfg_nxt;
			cmd_r     <= cmd_nxt;
			fire_r    <= fire_nxt;
		end
	end

	// Width mask of the active identifier size
	assign sel_w  = cfg_r[OBM_CFG_EXT] ? OBM_ID29_MASK : OBM_ID11_MASK;
	assign mask_w = nib_mask(dc_r) & sel_w;

	// Acceptance on every frame: mask one bits must match
	assign acc_w = (((32'(frame_in.id) ^ aid_r) & amsk_r) == OBM_ZERO32);

	// Monitor address filter on the header byte view
	always_comb begin
		mon_w = 1'b1;
		case (mode_r)
			OBM_MM_TX: mon_w = (frame_in.id[7:0] == maddr_r);
			OBM_MM_RX: begin
				if (frame_in.ext) begin
					mon_w = (rx_byte(frame_in) == maddr_r);
				end else begin
					mon_w = (rx_byte(frame_in) == {5'h00, maddr_r[2:0] & OBM_RX11_MSK});
				end
			end
			default: mon_w = 1'b1;
		endcase
	end

	// Core next state: commands, monitor, interrupt, display
	always_comb begin
		state_nxt = state_r;
		mode_nxt  = mode_r;
		maddr_nxt = maddr_r;
		hdr_nxt   = hdr_r;
		aid_nxt   = aid_r;
		amsk_nxt  = amsk_r;
		hraw_nxt  = hraw_r;
		dfr_nxt   = dfr_r;
		dval_nxt  = dval_r;
		drop_nxt  = 1'b0;
		stop_nxt  = 1'b0;
		srch_nxt  = 1'b0;
		kgs_nxt   = kgs_r;
		rchk_nxt  = 1'b0;
		// Display slot empties when the printer takes it
		if (dval_r && disp_ready) begin
			dval_nxt = 1'b0;
		end
		case (state_r)
			OBM_ST_IDLE: begin
				// Settings only change here, so a frame in print is untouched
				if (fire_r) begin
					case (cmd_r[OBM_OP_LSB +: 4])
						OBM_OP_SET_HDR: begin
							if (cmd_r[OBM_DIG_LSB +: 4] == OBM_DIG_SHORT) begin
								hdr_nxt = (hdr_r & OBM_PRIO_MSK) | (arg_r & OBM_SHORT_MSK);
							end else if (cmd_r[OBM_DIG_LSB +: 4] == OBM_DIG_FULL) begin
								hdr_nxt = arg_r & OBM_ID29_MASK;
							end else begin
								hdr_nxt = (hdr_r & OBM_PRIO_MSK) | (arg_r & OBM_HDR3_MSK);
							end
						end
						OBM_OP_MON_ALL, OBM_OP_MON_TX, OBM_OP_MON_RX: begin
							state_nxt = OBM_ST_MON;
							maddr_nxt = arg_r[7:0];
							case (cmd_r[OBM_OP_LSB +: 4])
								OBM_OP_MON_TX: mode_nxt = OBM_MM_TX;
								OBM_OP_MON_RX: mode_nxt = OBM_MM_RX;
								default:       mode_nxt = OBM_MM_ALL;
							endcase
							srch_nxt = cfg_r[OBM_CFG_AUTO] && bus_quiet;
						end
						OBM_OP_CRA: begin
							if (cmd_r[OBM_DIG_LSB +: 4] == OBM_DIG_NONE) begin
								amsk_nxt = OBM_ZERO32;
								aid_nxt  = OBM_ZERO32;
							end else begin
								amsk_nxt = mask_w;
								aid_nxt  = arg_r & mask_w;
							end
						end
						OBM_OP_HFMT_OFF: hraw_nxt = 1'b1;
						OBM_OP_HFMT_ON:  hraw_nxt = 1'b0;
						default: begin
						end
					endcase
				end
				// Replies outside monitor pass the acceptance test only
				if (frame_valid && acc_w && !dval_r) begin
					dfr_nxt  = frame_in;
					dval_nxt = 1'b1;
				end
			end
			OBM_ST_MON: begin
				if (frame_valid && acc_w && mon_w && !dval_r) begin
					dfr_nxt  = frame_in;
					dval_nxt = 1'b1;
				end
				// Any character value or RTS low ends monitoring
				if (rx_char_valid || !rts_sync_r) begin
					state_nxt = OBM_ST_STOP;
				end
				if (search_kline_9141 && cfg_r[OBM_CFG_AUTO]) begin
					kgs_nxt = 1'b1;
				end
			end
			OBM_ST_STOP: begin
				// Finish the line in progress before reporting
				if (!dval_r && !line_busy) begin
					stop_nxt  = 1'b1;
					state_nxt = OBM_ST_IDLE;
				end
			end
			default: state_nxt = OBM_ST_IDLE;
		endcase
		// Interrupting characters never reach the parser
		if (rx_char_valid && state_r != OBM_ST_IDLE) begin
			drop_nxt = 1'b1;
		end
		// Later diagnostic request re-runs the protocol choice
		if (kgs_r && diag_req && state_r == OBM_ST_IDLE) begin
			rchk_nxt = cfg_r[OBM_CFG_AUTO];
			kgs_nxt  = 1'b0;
		end
	end

	// Core flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r    <= OBM_ST_IDLE;
			mode_r     <= OBM_MM_ALL;
			maddr_r    <= OBM_ZERO8;
			hdr_r      <= OBM_HDR_RST;
			aid_r      <= OBM_ZERO32;
			amsk_r     <= OBM_ZERO32;
			hraw_r     <= 1'b0;
			dfr_r      <= '0;
			dval_r     <= 1'b0;
			drop_r     <= 1'b0;
			stop_r     <= 1'b0;
			srch_r     <= 1'b0;
			kgs_r      <= 1'b0;
			rchk_r     <= 1'b0;
			rts_meta_r <= 1'b1;
			rts_sync_r <= 1'b1;
		end else begin
			state_r    <= state_nxt;
			mode_r     <= mode_nxt;
			maddr_r    <= maddr_nxt;
			hdr_r      <= hdr_nxt;
			aid_r      <= aid_nxt;
			amsk_r     <= amsk_nxt;
			hraw_r     <= hraw_nxt;
			dfr_r      <= dfr_nxt;
			dval_r     <= dval_nxt;
			drop_r     <= drop_nxt;
			stop_r     <= stop_nxt;
			srch_r     <= srch_nxt;
			kgs_r      <= kgs_nxt;
			rchk_r     <= rchk_nxt;
			rts_meta_r <= rts_n_pin;
			rts_sync_r <= rts_meta_r;
		end
	end

	// Bus silence is registered from the next state, in step with the state register
	logic ack_r, wake_r, busy_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_r  <= 1'b1;
			wake_r <= 1'b1;
			busy_r <= 1'b0;
		end else begin
			ack_r  <= (state_nxt == OBM_ST_IDLE);
			wake_r <= (state_nxt == OBM_ST_IDLE);
			busy_r <= (state_nxt != OBM_ST_IDLE);
		end
	end

	assign s_axi_awready      = awready_r;
	assign s_axi_wready       = wready_r;
	assign s_axi_bvalid       = bvalid_r;
	assign s_axi_bresp        = bresp_r;
	assign s_axi_arready      = arready_r;
	assign s_axi_rvalid       = rvalid_r;
	assign s_axi_rdata        = rdata_r;
	assign s_axi_rresp        = rresp_r;
	assign disp_frame         = dfr_r;
	assign disp_valid         = dval_r;
	assign char_drop          = drop_r;
	assign stopped            = stop_r;
	assign busy               = busy_r;
	assign can_ack_en         = ack_r;
	assign wakeup_en          = wake_r;
	assign bus_quiet_unused_n = ack_r;
	assign search_start       = srch_r;
	assign kline_recheck      = rchk_r;
	assign hdr_raw            = hraw_r;
endmodule

// ### testbench/obm_monitor_chk.sv
module obm_monitor_chk
	import obm_pkg::*;
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       busy,
	input wire logic       can_ack_en,
	input wire logic       wakeup_en,
	input wire logic       rx_char_valid,
	input wire logic       rts_n_pin,
	input wire logic       char_drop,
	input wire logic       stopped,
	input wire logic       line_busy,
	input wire logic       disp_valid,
	input wire logic       disp_ready,
	input wire obm_frame_s disp_frame
);
	timeunit 1ns;
	timeprecision 1ns;
	// One clock domain, so clock and reset are stated once
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_silent_busy: assert property (busy |-> !can_ack_en && !wakeup_en)
		else $error("bus not silent while monitoring");
	a_talk_idle: assert property (!busy |-> can_ack_en && wakeup_en)
		else $error("bus silent while idle");
	a_char_dropped: assert property (rx_char_valid && busy |=> char_drop)
		else $error("interrupting char not dropped");
	a_drop_only_busy: assert property (char_drop |-> $past(busy))
		else $error("char dropped while idle");
	// Bounded by the slowest line the printer model takes
	a_char_stops: assert property (rx_char_valid && busy |-> ##[1:80] stopped)
		else $error("char did not stop monitoring");
	a_rts_stops: assert property (!rts_n_pin && busy |-> ##[1:80] stopped)
		else $error("rts low did not stop monitoring");
	a_stop_after_line: assert property (stopped |->
		!busy && !$past(disp_valid) && !$past(line_busy))
		else $error("stopped before line finished");
	a_busy_fall: assert property ($fell(busy) |-> stopped)
		else $error("busy fell without stopped");
	a_disp_hold: assert property (disp_valid && !disp_ready |=>
		disp_valid && $stable(disp_frame))
		else $error("shown frame changed before taken");
endmodule

bind obm_monitor obm_monitor_chk obm_monitor_chk_i (.aclk, .aresetn, .busy, .can_ack_en,
	.wakeup_en, .rx_char_valid, .rts_n_pin, .char_drop, .stopped, .line_busy, .disp_valid,
	.disp_ready, .disp_frame);

// ### testbench/obm_printer_model.sv
module obm_printer_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic slow,
	input  wire logic disp_valid,
	output logic      disp_ready,
	output logic      line_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	int wait_n; // Cycles waited before taking a frame
	int line_n; // Cycles left of the line in print
	bit take_b; // One-cycle take strobe, low from time zero
	assign disp_ready = take_b;
	assign line_busy  = (line_n > 0);
	// Take one frame, then print its line; nothing is taken mid-line
	always @(posedge aclk) begin
		take_b <= 1'b0;
		if (!aresetn) begin
			wait_n <= 0;
			line_n <= 0;
		end else if (line_n > 0) begin
			line_n <= line_n - 1;
		end else if (disp_valid && !take_b) begin
			// Slow mode stalls the take so a stop lands before the frame is taken
			if (wait_n < (slow ? 6 : 0)) begin
				wait_n <= wait_n + 1;
			end else begin
				take_b <= 1'b1;
				wait_n <= 0;
				line_n <= slow ? 12 : 2;
			end
		end
	end
endmodule

// ### testbench/tb_top.sv
module tb_top
	import obm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Bench-driven inputs start at a known level
	logic        aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        frame_valid = 1'b0, rx_char_valid = 1'b0, rts_n_pin = 1'b1;
	logic        bus_quiet = 1'b0, search_kline_9141 = 1'b0, diag_req = 1'b0, slow = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	obm_frame_s  frame_in = '0, disp_frame;
	// Design and printer model outputs
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        disp_valid, disp_ready, line_busy, char_drop, stopped, busy;
	logic        can_ack_en, wakeup_en, search_start, kline_recheck, hdr_raw, bus_quiet_unused_n;
	// Tallies of pulses and printed frames
	int          errors, total_checks, cyc, shown_n, drops, searches, rechecks;
	logic [28:0] last_id;

	obm_monitor #(.ADDR_W(8)) obm_monitor_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.frame_valid, .frame_in, .disp_frame, .disp_valid, .disp_ready, .line_busy,
		.rx_char_valid, .rts_n_pin, .char_drop, .stopped, .busy, .can_ack_en, .wakeup_en,
		.bus_quiet_unused_n, .bus_quiet, .search_start, .search_kline_9141, .diag_req,
		.kline_recheck, .hdr_raw);
	obm_printer_model obm_printer_model_i (.aclk, .aresetn, .slow, .disp_valid,
		.disp_ready, .line_busy);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Count port events; the cycle ceiling cuts a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (disp_valid && disp_ready) begin
			shown_n <= shown_n + 1;
			last_id <= disp_frame.id;
		end
		if (char_drop) drops <= drops + 1;
		if (search_start) searches <= searches + 1;
		if (kline_recheck) rechecks <= rechecks + 1;
		if (cyc == 20000) begin
			errors++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input bit ok, input string m);
		total_checks++;
		if (!ok) begin
			errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp === r, "write response");
		// One quiet edge so a following call never rewrites bready in this step
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata === e && s_axi_rresp === r, "read data or response");
		// One quiet edge so a following read never re-raises arvalid in this step
		@(posedge aclk);
	endtask

	// Argument, digit mask, then the command word; it acts two cycles on
	task automatic cmd(input logic [3:0] op, input logic [3:0] dg, input logic [31:0] a,
		input logic [31:0] dc);
		wr(OBM_REG_ARG, a, OBM_RESP_OK);
		wr(OBM_REG_DC, dc, OBM_RESP_OK);
		wr(OBM_REG_CMD, {24'h00_0000, dg, op}, OBM_RESP_OK);
		repeat (3) @(posedge aclk);
	endtask

	// One received frame; n is how many prints it should cause
	task automatic frm(input logic x, input logic [28:0] id, input int n);
		int n0;
		n0 = shown_n;
		frame_in <= '{x, id};
		frame_valid <= 1'b1;
		@(posedge aclk);
		frame_valid <= 1'b0;
		repeat (30) @(posedge aclk);
		chk(shown_n - n0 == n, "frame print count");
		if (n > 0) chk(last_id === id, "printed frame id");
	endtask

	// Interrupt by char or RTS, then wait for busy to fall before going on
	task automatic halt(input bit by_rts);
		int n0;
		n0 = drops;
		if (by_rts) rts_n_pin <= 1'b0;
		else rx_char_valid <= 1'b1;
		@(posedge aclk);
		rx_char_valid <= 1'b0;
		repeat (80) begin
			@(posedge aclk);
			if (busy === 1'b0) break;
		end
		rts_n_pin <= 1'b1;
		chk(busy === 1'b0, "still busy after interrupt");
		chk(drops - n0 == (by_rts ? 0 : 1), "dropped char count");
	endtask

	initial begin
		int s0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(can_ack_en === 1'b1 && busy === 1'b0, "reset outputs");
		chk(bus_quiet_unused_n === 1'b1, "spare ack copy idle");
		rd(OBM_REG_STAT, 32'h0000_0001, OBM_RESP_OK);
		rd(OBM_REG_AMSK, 32'h0000_0000, OBM_RESP_OK);
		rd(8'h20, 32'h0000_0000, OBM_RESP_ERR);
		wr(8'h24, 32'h0000_0000, OBM_RESP_ERR);
		frm(1'b0, 29'h123, 1);
		// Header store: full form, then short form padded with zeros
		cmd(OBM_OP_SET_HDR, OBM_DIG_FULL, 32'hFF12_3456, 32'h0000_0000);
		rd(OBM_REG_HDR, 32'h1F12_3456, OBM_RESP_OK);
		cmd(OBM_OP_SET_HDR, OBM_DIG_SHORT, 32'h00AB_C7E0, 32'h0000_0000);
		rd(OBM_REG_HDR, 32'h1F00_07E0, OBM_RESP_OK);
		cmd(OBM_OP_SET_HDR, 4'h6, 32'hEEA8_48F1, 32'h0000_0000);
		rd(OBM_REG_HDR, 32'h1FA8_48F1, OBM_RESP_OK);
		// Exact, then nibble don't-care acceptance
		cmd(OBM_OP_CRA, OBM_DIG_SHORT, 32'h0000_07E9, 32'h0000_0000);
		rd(OBM_REG_AMSK, 32'h0000_07FF, OBM_RESP_OK);
		frm(1'b0, 29'h7E9, 1);
		frm(1'b0, 29'h7E8, 0);
		cmd(OBM_OP_CRA, OBM_DIG_SHORT, 32'h0000_07E0, 32'h0000_0001);
		rd(OBM_REG_AMSK, 32'h0000_07F0, OBM_RESP_OK);
		frm(1'b0, 29'h7E0, 1);
		frm(1'b0, 29'h7EF, 1);
		frm(1'b0, 29'h7F0, 0);
		// 29-bit bus; top three priority bits of the argument ignored
		wr(OBM_REG_CFG, 32'h0000_0002, OBM_RESP_OK);
		cmd(OBM_OP_CRA, OBM_DIG_FULL, 32'hF8DA_F110, 32'h0000_0003);
		rd(OBM_REG_AMSK, 32'h1FFF_FF00, OBM_RESP_OK);
		rd(OBM_REG_AID, 32'h18DA_F100, OBM_RESP_OK);
		frm(1'b1, 29'h18DA_F1AB, 1);
		frm(1'b1, 29'h18DA_F2AB, 0);
		cmd(OBM_OP_CRA, OBM_DIG_NONE, 32'h0000_0000, 32'h0000_0000);
		wr(OBM_REG_CFG, 32'h0000_0000, OBM_RESP_OK);
		// Transmitter filter on 11-bit ids, stopped by a char
		cmd(OBM_OP_MON_TX, OBM_DIG_NONE, 32'h0000_0010, 32'h0000_0000);
		chk(busy === 1'b1 && can_ack_en === 1'b0 && wakeup_en === 1'b0, "silent");
		chk(bus_quiet_unused_n === 1'b0, "spare ack copy silent");
		frm(1'b0, 29'h710, 1);
		frm(1'b0, 29'h711, 0);
		halt(1'b0);
		// Receiver filter keeps only the low three address bits on 11-bit ids, the whole byte on 29-bit
		cmd(OBM_OP_MON_RX, OBM_DIG_NONE, 32'h0000_0010, 32'h0000_0000);
		frm(1'b0, 29'h0AB, 1);
		frm(1'b0, 29'h1AB, 0);
		frm(1'b1, 29'h18DA_10F1, 1);
		frm(1'b1, 29'h18DA_F110, 0);
		halt(1'b1);
		// Monitor all on a quiet bus with automatic search
		bus_quiet <= 1'b1;
		wr(OBM_REG_CFG, 32'h0000_0001, OBM_RESP_OK);
		s0 = searches;
		cmd(OBM_OP_MON_ALL, OBM_DIG_NONE, 32'h0000_0000, 32'h0000_0000);
		chk(searches > s0, "protocol search start");
		bus_quiet <= 1'b0;
		frm(1'b0, 29'h456, 1);
		frm(1'b0, 29'h7FF, 1);
		search_kline_9141 <= 1'b1;
		@(posedge aclk);
		search_kline_9141 <= 1'b0;
		// Interrupt while a slow frame still waits to be taken
		slow <= 1'b1;
		s0 = shown_n;
		frame_in <= '{1'b0, 29'h321};
		frame_valid <= 1'b1;
		@(posedge aclk);
		frame_valid <= 1'b0;
		@(posedge aclk);
		halt(1'b0);
		chk(shown_n - s0 == 1, "line in print finished");
		slow <= 1'b0;
		diag_req <= 1'b1;
		@(posedge aclk);
		diag_req <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(rechecks > 0, "k-line recheck");
		cmd(OBM_OP_HFMT_OFF, OBM_DIG_NONE, 32'h0000_0000, 32'h0000_0000);
		chk(hdr_raw === 1'b1, "raw header on");
		cmd(OBM_OP_HFMT_ON, OBM_DIG_NONE, 32'h0000_0000, 32'h0000_0000);
		chk(hdr_raw === 1'b0, "raw header off");
		summarize();
	end
endmodule
